// ---- dv/buck_control_sequencer_assertions.sv ----
// concurrent checks on the buck sequencer top ports
`timescale 1ns/1ps
module buck_seq_checker (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_ENABLE,
  input wire logic I_PULSE_DEMAND,
  input wire logic I_MIN_OFF_REACHED,
  input wire logic I_OVER_TEMP,
  input wire logic I_HS_GATE_LOW,
  input wire logic I_LS_GATE_LOW,
  input wire logic O_HIGH_SIDE_DRIVE,
  input wire logic O_LOW_SIDE_DRIVE,
  input wire logic O_SOFT_START_PULL_LOW,
  input wire logic O_POWER_GOOD_OR_SYNC_OUT,
  input wire logic O_ERR_AMP_ENABLE,
  input wire logic O_INT_COMP_ENABLE,
  input wire logic O_SPREAD_SPECTRUM,
  input wire logic O_USE_EXT_CLOCK,
  input wire logic O_SLEEP,
  input wire logic O_VCC_REG_ENABLE
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  drive_overlap_a: assert property (!(O_HIGH_SIDE_DRIVE && O_LOW_SIDE_DRIVE))
    else $error("both drives on");
  high_turn_on_a: assert property ($rose(O_HIGH_SIDE_DRIVE) |-> $past(I_LS_GATE_LOW) && !$past(O_LOW_SIDE_DRIVE))
    else $error("high side too early");
  low_dead_time_a: assert property ($rose(O_LOW_SIDE_DRIVE) |->
    $past(I_HS_GATE_LOW) && $past(I_HS_GATE_LOW, 2) && !$past(O_HIGH_SIDE_DRIVE))
    else $error("no dead time");
  thermal_stop_a: assert property (I_OVER_TEMP [*3] |-> !O_HIGH_SIDE_DRIVE && !O_LOW_SIDE_DRIVE
    && !O_VCC_REG_ENABLE && !O_POWER_GOOD_OR_SYNC_OUT && O_SOFT_START_PULL_LOW)
    else $error("thermal stop");
  disable_stop_a: assert property (!I_ENABLE [*3] |-> O_SOFT_START_PULL_LOW && !O_HIGH_SIDE_DRIVE)
    else $error("still running");
  spread_no_sync_a: assert property (O_SPREAD_SPECTRUM |-> !O_USE_EXT_CLOCK)
    else $error("spread took sync");
  min_off_a: assert property (I_MIN_OFF_REACHED |-> !O_USE_EXT_CLOCK)
    else $error("sync at min off");
  strap_held_a: assert property ($past(I_ARST_N, 2) |->
    $stable(O_SPREAD_SPECTRUM) && $stable(O_ERR_AMP_ENABLE) && $stable(O_INT_COMP_ENABLE))
    else $error("strap changed");
  comp_path_a: assert property (O_INT_COMP_ENABLE |-> O_ERR_AMP_ENABLE)
    else $error("int comp on secondary");
  sleep_wake_a: assert property (O_SLEEP && I_PULSE_DEMAND |=> !O_SLEEP)
    else $error("demand did not wake");
endmodule // buck_seq_checker

// ---- dv/buck_control_sequencer_bench.sv ----
// self-checking bench for the buck sequencer
`timescale 1ns/1ps
module buck_control_sequencer_bench;
  // ------------------------------------------------------------
  // hookup
  // ------------------------------------------------------------
  logic I_CLK = 0, I_ARST_N = 0, I_AVS_READ = 0, I_AVS_WRITE = 0, I_ENABLE = 0, I_INT_COMP_DETECT = 1;
  logic I_SW_TICK = 0, I_LIGHT_LOAD_OR_SYNC_IN = 0, I_CUR_LIMIT = 0, I_FEEDBACK_ABOVE_MIN = 0, I_PWM_ON = 0;
  logic I_PULSE_DEMAND = 1, I_ZERO_CROSS = 0, I_PREBIAS = 0, I_MIN_OFF_REACHED = 0, I_OVER_TEMP = 0;
  logic I_PGOOD_OK = 1, slow = 0, sync_on = 0;
  logic [3:0] I_AVS_ADDRESS = 4'h0, I_AVS_BYTEENABLE = 4'hf;
  logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, q;
  logic [2:0] I_CONFIG_STRAP = 3'h4;
  logic O_AVS_WAITREQUEST, O_HIGH_SIDE_DRIVE, O_LOW_SIDE_DRIVE, O_SOFT_START_PULL_LOW, O_POWER_GOOD_OR_SYNC_OUT;
  logic O_ERR_AMP_ENABLE, O_INT_COMP_ENABLE, O_SPREAD_SPECTRUM, O_USE_EXT_CLOCK, O_SLEEP, O_VCC_REG_ENABLE;
  logic I_HS_GATE_LOW, I_LS_GATE_LOW;
  int errors = 0, comparisons = 0, seed = 99576, mst, cnt, cln, off, sec, spr, dual;
  buck_control_sequencer #(.OFF_TIME_CYCLES(32)) u_dut (.*);
  buck_power_stage u_stage (.i_clk(I_CLK), .i_hs(O_HIGH_SIDE_DRIVE), .i_ls(O_LOW_SIDE_DRIVE),
    .i_slow(slow), .o_hs_gate_low(I_HS_GATE_LOW), .o_ls_gate_low(I_LS_GATE_LOW));
  initial forever #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    if (($random(seed) & 7) == 0) I_PWM_ON <= ~I_PWM_ON;
    I_ZERO_CROSS <= ($random(seed) & 15) == 0;
  end
  // 250-cycle period, inside the lock window
  always begin
    repeat (125) @(posedge I_CLK);
    if (sync_on) I_LIGHT_LOAD_OR_SYNC_IN <= ~I_LIGHT_LOAD_OR_SYNC_IN;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done(input bit fail);
    if (fail) errors++;
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge I_CLK);
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= d;
    I_AVS_WRITE <= w;
    I_AVS_READ <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge I_CLK);
      if (O_AVS_WAITREQUEST === 1'b0) break;
    end
    q = O_AVS_READDATA;
    I_AVS_WRITE <= 1'b0;
    I_AVS_READ <= 1'b0;
    if (n == 20) test_done(1);
  endtask
  task automatic st(input int m);
    mst = m;
    bus(0, 4'h4, 0);
    check("state", q & 32'h1f, mst);
  endtask
  task automatic hc();
    bus(0, 4'hc, 0);
    check("count", q, cnt);
  endtask
  task automatic tick(input logic cl);
    @(posedge I_CLK);
    I_SW_TICK <= 1'b1;
    I_CUR_LIMIT <= cl;
    @(posedge I_CLK);
    I_SW_TICK <= 1'b0;
    I_CUR_LIMIT <= 1'b0;
    cyc(1);
    if (mst == 4) begin
      cln = cl ? 0 : cln + 1;
      if (cl || cnt > 0) cnt++;
      if (cln == 4) cnt = 0;
      if (cnt == 512) begin
        mst = 8;
        off = 0;
      end
    end else if (mst == 8 && ++off == 32) mst = 2;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    for (int c = 4; c >= 0; c--) begin
      I_CONFIG_STRAP <= c[2:0];
      I_INT_COMP_DETECT <= 1'b1;
      I_ARST_N <= 1'b0;
      cyc(6);
      I_ARST_N <= 1'b1;
      cyc(2);
      sec = c == 4;
      spr = c == 1 || c == 3;
      dual = c >= 2;
      I_CONFIG_STRAP <= (c == 4) ? 3'h0 : 3'h4;
      I_INT_COMP_DETECT <= 1'b0;
      cyc(4);
      bus(0, 4'h8, 0);
      check("config", q, 32'h108 | dual << 2 | spr << 1 | sec);
      check("err amp", O_ERR_AMP_ENABLE, !sec);
      check("int comp", O_INT_COMP_ENABLE, !dual);
      check("spread", O_SPREAD_SPECTRUM, spr);
    end
    bus(0, 4'h0, 0);
    check("ctrl", q, 32'h3);
    bus(0, 4'h2, 0);
    check("unmapped", q, 0);
    I_AVS_BYTEENABLE <= 4'he;
    bus(1, 4'h0, 0);
    I_AVS_BYTEENABLE <= 4'hf;
    bus(0, 4'h0, 0);
    check("ctrl kept", q, 32'h3);
    I_ENABLE <= 1'b1;
    cyc(3);
    st(2);
    bus(1, 4'h0, 2);
    st(1);
    bus(1, 4'h0, 3);
    cyc(3);
    st(2);
    repeat (2) tick(1);
    hc();
    I_FEEDBACK_ABOVE_MIN <= 1'b1;
    cyc(3);
    cnt = 0;
    st(4);
    repeat (10) tick(1);
    repeat (3) tick(0);
    hc();
    tick(0);
    hc();
    repeat (511) tick(1);
    st(mst);
    tick(1);
    I_FEEDBACK_ABOVE_MIN <= 1'b0;
    st(mst);
    check("drives", {O_HIGH_SIDE_DRIVE, O_LOW_SIDE_DRIVE, O_SOFT_START_PULL_LOW}, 1);
    repeat (31) tick(0);
    st(mst);
    tick(0);
    st(mst);
    I_FEEDBACK_ABOVE_MIN <= 1'b1;
    slow <= 1'b1;
    cyc(3);
    mst = 4;
    I_LIGHT_LOAD_OR_SYNC_IN <= 1'b1;
    cyc(2100);
    bus(0, 4'h4, 0);
    check("diode emu", q[10], 1);
    I_PULSE_DEMAND <= 1'b0;
    repeat (16) tick(0);
    check("sleep", O_SLEEP, 0);
    tick(0);
    check("sleep", O_SLEEP, 1);
    I_PULSE_DEMAND <= 1'b1;
    cyc(2);
    check("wake", O_SLEEP, 0);
    sync_on = 1;
    cyc(1000);
    check("ext clock", O_USE_EXT_CLOCK, 1);
    I_MIN_OFF_REACHED <= 1'b1;
    cyc(2);
    check("min off", O_USE_EXT_CLOCK, 0);
    I_MIN_OFF_REACHED <= 1'b0;
    sync_on = 0;
    cyc(2);
    I_LIGHT_LOAD_OR_SYNC_IN <= 1'b0;
    cyc(2100);
    bus(0, 4'h4, 0);
    check("forced pwm", {q[11:10], O_USE_EXT_CLOCK}, 0);
    I_FEEDBACK_ABOVE_MIN <= 1'b0;
    I_OVER_TEMP <= 1'b1;
    cyc(3);
    st(16);
    check("vcc reg", O_VCC_REG_ENABLE, 0);
    I_OVER_TEMP <= 1'b0;
    cyc(3);
    st(2);
    test_done(0);
  end
endmodule // buck_control_sequencer_bench
bind buck_control_sequencer buck_seq_checker u_chk (.I_CLK, .I_ARST_N, .I_ENABLE, .I_PULSE_DEMAND,
  .I_MIN_OFF_REACHED, .I_OVER_TEMP, .I_HS_GATE_LOW, .I_LS_GATE_LOW, .O_HIGH_SIDE_DRIVE, .O_LOW_SIDE_DRIVE,
  .O_SOFT_START_PULL_LOW, .O_POWER_GOOD_OR_SYNC_OUT, .O_ERR_AMP_ENABLE, .O_INT_COMP_ENABLE,
  .O_SPREAD_SPECTRUM, .O_USE_EXT_CLOCK, .O_SLEEP, .O_VCC_REG_ENABLE);

// ---- dv/buck_power_stage.sv ----
// gate sense model of the external power stage
`timescale 1ns/1ps
module buck_power_stage (
  input wire logic i_clk,
  input wire logic i_hs,
  input wire logic i_ls,
  input wire logic i_slow,
  output logic o_hs_gate_low,
  output logic o_ls_gate_low
);
  // ------------------------------------------------------------
  // gate discharge
  // ------------------------------------------------------------
  logic [3:0] hs_hist = 4'h0;
  logic [3:0] ls_hist = 4'h0;
  always @(posedge i_clk) begin
    hs_hist <= {hs_hist[2:0], i_hs};
    ls_hist <= {ls_hist[2:0], i_ls};
  end
  // four-cycle slow gates make the interlock wait
  assign o_hs_gate_low = !i_hs && !(i_slow ? |hs_hist : hs_hist[0]);
  assign o_ls_gate_low = !i_ls && !(i_slow ? |ls_hist : ls_hist[0]);
endmodule // buck_power_stage

// ---- hw/buck_control_sequencer.sv ----
// supervisory and sequencing logic of the synchronous buck controller
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// (RL1) after overload, 512 switching cycles of cycle-by-cycle limiting before further action
// (RL2) four clean switching cycles in a row clear the overload counter
// (RL3) overload expiry pulls soft-start low, stops both drives, starts off-time count
// (RL4) after 16384 off-time cycles, release soft-start and restart switching
// (RL5) hiccup inactive during soft-start until feedback exceeds 0.4 V
// (RL6) low-side waits for high-side off, its gate low, then a delay
// (RL7) high-side waits for low-side gate low; drives never on together
// (RL8) strap latched after supply good; changes only after power cycle
// (RL9) strap decodes to five primary/secondary, spread, dual-phase settings
// (RL10) primary with spread spectrum never synchronises to external clock
// (RL11) secondary disables its error amplifier, output left high-impedance
// (RL12) dual-phase forbids internal compensation; external path only
// (RL13) dual-phase primary outputs sync clock shifted 180 degrees on power-good pin
// (RL14) external sync applied later locks after two clock cycles
// (RL15) pulse skipping stops sync output; phase shedding only in forced PWM
// (RL16) re-enabled secondary pulls soft-start low and restarts full soft-start
// (RL17) diode emulation sleeps after 16 consecutive cycles with no pulse demanded
// (RL18) diode emulation cuts low-side on reverse current; forced during prebias
// (RL19) light-load pin: high diode emulation, low forced PWM, toggling external sync
// (RL20) valid external clock overrides resistor rate within 20 percent, max 2.5 MHz
// (RL21) at minimum off-time the sync clock is ignored
// (RL22) over-temperature stops drives, power-good low, regulator off; retries when cooled
// (RL23) system enables both controllers together; shedding only in forced PWM
// (RL24) counters step per active switching cycle and clear on undervoltage reset
module buck_control_sequencer #(
  parameter int OFF_TIME_CYCLES = buck_seq_pkg::OFF_TIME_CYCLES,
  parameter int PROG_PERIOD_CYC = buck_seq_pkg::PROG_PERIOD_CYC
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_ENABLE,
  input wire logic [2:0] I_CONFIG_STRAP,
  input wire logic I_INT_COMP_DETECT,
  input wire logic I_SW_TICK,
  input wire logic I_LIGHT_LOAD_OR_SYNC_IN,
  input wire logic I_CUR_LIMIT,
  input wire logic I_FEEDBACK_ABOVE_MIN,
  input wire logic I_PWM_ON,
  input wire logic I_PULSE_DEMAND,
  input wire logic I_ZERO_CROSS,
  input wire logic I_PREBIAS,
  input wire logic I_MIN_OFF_REACHED,
  input wire logic I_OVER_TEMP,
  input wire logic I_PGOOD_OK,
  input wire logic I_HS_GATE_LOW,
  input wire logic I_LS_GATE_LOW,
  output logic O_HIGH_SIDE_DRIVE,
  output logic O_LOW_SIDE_DRIVE,
  output logic O_SOFT_START_PULL_LOW,
  output logic O_POWER_GOOD_OR_SYNC_OUT,
  output logic O_ERR_AMP_ENABLE,
  output logic O_INT_COMP_ENABLE,
  output logic O_SPREAD_SPECTRUM,
  output logic O_USE_EXT_CLOCK,
  output logic O_SLEEP,
  output logic O_VCC_REG_ENABLE
);
  localparam int OFF_W = $clog2(OFF_TIME_CYCLES + 1);
  localparam int STATIC_W = $clog2(buck_seq_pkg::STATIC_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    buck_seq_pkg::seq_state_t seq;
    logic strap_taken;
    buck_seq_pkg::strap_cfg_t cfg;
    logic int_comp;
    logic [OFF_W-1:0] off_cnt;
    logic [1:0] ctrl;
    logic ack;
    logic [31:0] rdata;
    logic lls_prev;
    logic [STATIC_W-1:0] static_cnt;
    logic toggling;
    logic [1:0] ext_edges;
    logic ext_locked;
    logic [11:0] ext_per;
    logic [4:0] miss_cnt;
    logic dem_seen;
    logic sleep;
    logic zc_seen;
    logic [11:0] sw_cnt;
    logic [11:0] sw_period;
    logic sync_out;
    logic pin_out;
  } top_state_t;
  top_state_t s;
  top_state_t next_s;

  logic ext_rise;
  logic use_ext;
  logic tick;
  logic en;
  logic diode_emu;
  logic skipping;
  logic drive_en;
  logic hs_req;
  logic ls_req;
  logic hic_expired;
  logic [9:0] hic_count;
  logic [31:0] status_word;
  logic [31:0] config_word;

  // edge period within tolerance and under the max rate
  function automatic logic period_ok(input logic [11:0] per);
    int p;
    p = int'(per);
    return (p >= buck_seq_pkg::SYNC_MIN_PERIOD)
      && (p * 100 >= PROG_PERIOD_CYC * (100 - buck_seq_pkg::SYNC_TOL_PCT))
      && (p * 100 <= PROG_PERIOD_CYC * (100 + buck_seq_pkg::SYNC_TOL_PCT));
  endfunction

  // ----------------------------------------------------------------
  // mode and clock selection
  // ----------------------------------------------------------------
  assign ext_rise = I_LIGHT_LOAD_OR_SYNC_IN && !s.lls_prev;
  // spread-spectrum primary and min off-time both bypass the external clock
  assign use_ext = s.ext_locked && !(s.cfg.spread && !s.cfg.secondary) && !I_MIN_OFF_REACHED; // RL10 RL21
  assign tick = use_ext ? ext_rise : I_SW_TICK; // RL20 RL24
  assign en = I_ENABLE && s.ctrl[buck_seq_pkg::CTRL_EN_BIT];
  assign diode_emu = (!s.toggling && I_LIGHT_LOAD_OR_SYNC_IN) || I_PREBIAS; // RL19 RL18
  assign skipping = diode_emu && (s.sleep || s.miss_cnt != 5'h00);
  assign drive_en = (s.seq == buck_seq_pkg::ST_SOFT || s.seq == buck_seq_pkg::ST_RUN) && !s.sleep;
  assign hs_req = I_PWM_ON && drive_en;
  // in diode emulation, reverse current ends the low-side conduction for the rest of the cycle
  assign ls_req = !I_PWM_ON && drive_en && !(diode_emu && (s.zc_seen || I_ZERO_CROSS)); // RL18

  // ----------------------------------------------------------------
  // register read words
  // ----------------------------------------------------------------
  assign status_word = {20'h00000, use_ext, diode_emu, s.ext_locked, s.sleep, 3'h0, s.seq};
  assign config_word = {23'h000000, s.strap_taken, 4'h0, s.int_comp, s.cfg.dual, s.cfg.spread,
                        s.cfg.secondary};

  always_comb begin
    next_s = s;

    // strap captured once per power-up; only reset clears it
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1; // RL8
      next_s.cfg = buck_seq_pkg::decode_strap(I_CONFIG_STRAP); // RL9
      next_s.int_comp = I_INT_COMP_DETECT;
    end

    // ------------------------------------------------------------
    // external clock detection and lock
    // ------------------------------------------------------------
    next_s.lls_prev = I_LIGHT_LOAD_OR_SYNC_IN;
    if (s.ext_per != 12'hfff) begin
      next_s.ext_per = s.ext_per + 12'h001;
    end
    if (ext_rise || (I_LIGHT_LOAD_OR_SYNC_IN != s.lls_prev)) begin
      next_s.static_cnt = '0;
      next_s.toggling = 1'b1; // RL19
    end else if (s.static_cnt == STATIC_W'(buck_seq_pkg::STATIC_CYC)) begin
      next_s.toggling = 1'b0;
      next_s.ext_edges = '0;
      next_s.ext_locked = 1'b0;
    end else begin
      next_s.static_cnt = s.static_cnt + STATIC_W'(1);
    end
    if (ext_rise) begin
      next_s.ext_per = 12'h000;
      if (period_ok(s.ext_per)) begin // RL20
        if (s.ext_edges != 2'(buck_seq_pkg::SYNC_LOCK_EDGES)) begin
          next_s.ext_edges = s.ext_edges + 2'h1;
        end
        if (s.ext_edges == 2'(buck_seq_pkg::SYNC_LOCK_EDGES - 1)) begin
          next_s.ext_locked = 1'b1; // RL14
        end
      end else begin
        next_s.ext_edges = '0;
        next_s.ext_locked = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // per-cycle demand, sleep and zero-cross tracking
    // ------------------------------------------------------------
    next_s.dem_seen = s.dem_seen || I_PULSE_DEMAND;
    next_s.zc_seen = s.zc_seen || I_ZERO_CROSS;
    if (tick) begin
      // an event in the tick cycle belongs to the new cycle
      next_s.zc_seen = I_ZERO_CROSS;
      next_s.dem_seen = I_PULSE_DEMAND;
      if (s.dem_seen || I_PULSE_DEMAND || !diode_emu) begin
        next_s.miss_cnt = '0;
      end else if (s.miss_cnt != 5'(buck_seq_pkg::SLEEP_MISSED_CYCLES)) begin
        next_s.miss_cnt = s.miss_cnt + 5'h01;
      end
      if (!s.dem_seen && !I_PULSE_DEMAND && diode_emu && s.ctrl[buck_seq_pkg::CTRL_SLEEP_BIT]
          && s.miss_cnt == 5'(buck_seq_pkg::SLEEP_MISSED_CYCLES - 1)) begin
        next_s.sleep = 1'b1; // RL17
      end
    end
    if (I_PULSE_DEMAND || !diode_emu || !drive_en) begin
      next_s.sleep = 1'b0;
    end

    // ------------------------------------------------------------
    // switching period measure and half-period sync clock
    // ------------------------------------------------------------
    if (tick) begin
      next_s.sw_period = s.sw_cnt;
      next_s.sw_cnt = 12'h000;
    end else if (s.sw_cnt != 12'hfff) begin
      next_s.sw_cnt = s.sw_cnt + 12'h001;
    end
    next_s.sync_out = (s.sw_cnt >= (s.sw_period >> 1)); // RL13
    if (s.cfg.dual && !s.cfg.secondary) begin
      // pulse skipping stops the clock, which takes phase shedding with it
      next_s.pin_out = s.sync_out && !skipping && drive_en; // RL15
    end else begin
      next_s.pin_out = I_PGOOD_OK && s.seq == buck_seq_pkg::ST_RUN; // RL22
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    case (s.seq)
      buck_seq_pkg::ST_OFF: begin
        // soft-start held low here, so every re-enable starts from zero
        if (en && s.strap_taken) begin
          next_s.seq = buck_seq_pkg::ST_SOFT; // RL16
        end
      end
      buck_seq_pkg::ST_SOFT: begin
        if (!en) begin
          next_s.seq = buck_seq_pkg::ST_OFF;
        end else if (I_FEEDBACK_ABOVE_MIN) begin
          next_s.seq = buck_seq_pkg::ST_RUN; // RL5
        end
      end
      buck_seq_pkg::ST_RUN: begin
        if (!en) begin
          next_s.seq = buck_seq_pkg::ST_OFF;
        end else if (hic_expired) begin
          next_s.seq = buck_seq_pkg::ST_HICCUP; // RL3
          next_s.off_cnt = '0;
        end
      end
      buck_seq_pkg::ST_HICCUP: begin
        if (!en) begin
          next_s.seq = buck_seq_pkg::ST_OFF;
        end else if (tick) begin
          next_s.off_cnt = s.off_cnt + OFF_W'(1);
          if (s.off_cnt == OFF_W'(OFF_TIME_CYCLES - 1)) begin
            next_s.seq = buck_seq_pkg::ST_SOFT; // RL4
          end
        end
      end
      buck_seq_pkg::ST_THERMAL: begin
        // hysteresis lives in the comparator
        if (!I_OVER_TEMP) begin
          next_s.seq = buck_seq_pkg::ST_SOFT; // RL22
        end
      end
      default: begin
        next_s.seq = buck_seq_pkg::ST_OFF;
      end
    endcase
    if (I_OVER_TEMP) begin
      next_s.seq = buck_seq_pkg::ST_THERMAL; // RL22
    end

    // ------------------------------------------------------------
    // avalon slave, one wait state
    // ------------------------------------------------------------
    next_s.ack = (I_AVS_READ || I_AVS_WRITE) && !s.ack;
    if (I_AVS_READ && !s.ack) begin
      case (I_AVS_ADDRESS)
        buck_seq_pkg::OFS_CTRL: next_s.rdata = {30'h00000000, s.ctrl};
        buck_seq_pkg::OFS_STATUS: next_s.rdata = status_word;
        buck_seq_pkg::OFS_CONFIG: next_s.rdata = config_word;
        buck_seq_pkg::OFS_HICCUP: next_s.rdata = {22'h000000, hic_count};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    if (I_AVS_WRITE && s.ack && I_AVS_ADDRESS == buck_seq_pkg::OFS_CTRL && I_AVS_BYTEENABLE[0]) begin
      next_s.ctrl = I_AVS_WRITEDATA[1:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s <= '0; // RL24
      s.seq <= buck_seq_pkg::ST_OFF;
      s.ctrl <= buck_seq_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // protection and drive submodules
  // ----------------------------------------------------------------
  hiccup_counter u_hiccup (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_tick(tick),
    .i_armed(s.seq == buck_seq_pkg::ST_RUN), // RL5
    .i_cur_limit(I_CUR_LIMIT),
    .o_expired(hic_expired),
    .o_count(hic_count)
  );

  dead_time_interlock u_dead_time (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_hs_req(hs_req),
    .i_ls_req(ls_req),
    .i_hs_gate_low(I_HS_GATE_LOW),
    .i_ls_gate_low(I_LS_GATE_LOW),
    .o_hs(O_HIGH_SIDE_DRIVE), // RL7
    .o_ls(O_LOW_SIDE_DRIVE) // RL6
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_SOFT_START_PULL_LOW = (s.seq == buck_seq_pkg::ST_OFF) || (s.seq == buck_seq_pkg::ST_HICCUP)
                                 || (s.seq == buck_seq_pkg::ST_THERMAL); // RL3 RL16
  assign O_POWER_GOOD_OR_SYNC_OUT = s.pin_out;
  assign O_ERR_AMP_ENABLE = s.strap_taken && !s.cfg.secondary; // RL11
  assign O_INT_COMP_ENABLE = s.strap_taken && s.int_comp && !s.cfg.dual; // RL12
  assign O_SPREAD_SPECTRUM = s.cfg.spread && !s.cfg.secondary;
  assign O_USE_EXT_CLOCK = use_ext;
  assign O_SLEEP = s.sleep;
  assign O_VCC_REG_ENABLE = (s.seq != buck_seq_pkg::ST_THERMAL); // RL22
  assign O_AVS_READDATA = s.rdata;
  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !s.ack;
endmodule // buck_control_sequencer

// ---- hw/buck_seq_pkg.sv ----
// shared constants, types and strap decode for the buck sequencer
package buck_seq_pkg;
  // ----------------------------------------------------------------
  // clock and protection counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int OVERLOAD_CYCLES = 512;
  localparam int CLEAN_CYCLES = 4;
  localparam int OFF_TIME_CYCLES = 16384;
  localparam int SLEEP_MISSED_CYCLES = 16;
  localparam int SYNC_LOCK_EDGES = 2;
  localparam int DT_DELAY_NS = 20;
  localparam int DT_DELAY_CYC = (DT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MAX_KHZ = 2500;
  localparam int SYNC_MIN_PERIOD = (1000000 + SYNC_MAX_KHZ * CLK_PERIOD_NS - 1) / (SYNC_MAX_KHZ * CLK_PERIOD_NS);
  localparam int SYNC_TOL_PCT = 20;
  localparam int PROG_PERIOD_CYC = 250;
  localparam int STATIC_NS = 20000;
  localparam int STATIC_CYC = STATIC_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CONFIG = 4'h8;
  localparam logic [3:0] OFS_HICCUP = 4'hc;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  // ----------------------------------------------------------------
  // strap codes and types
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_PRI_SINGLE = 3'h0;
  localparam logic [2:0] STRAP_PRI_SS_SINGLE = 3'h1;
  localparam logic [2:0] STRAP_PRI_DUAL = 3'h2;
  localparam logic [2:0] STRAP_PRI_SS_DUAL = 3'h3;
  localparam logic [2:0] STRAP_SECONDARY = 3'h4;
  typedef struct packed {
    logic secondary;
    logic spread;
    logic dual;
  } strap_cfg_t;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_SOFT = 5'h02,
    ST_RUN = 5'h04,
    ST_HICCUP = 5'h08,
    ST_THERMAL = 5'h10
  } seq_state_t;
  function automatic strap_cfg_t decode_strap(input logic [2:0] code);
    strap_cfg_t c;
    c = '{secondary: 1'b0, spread: 1'b0, dual: 1'b0};
    case (code)
      STRAP_PRI_SS_SINGLE: c.spread = 1'b1;
      STRAP_PRI_DUAL: c.dual = 1'b1;
      STRAP_PRI_SS_DUAL: c = '{secondary: 1'b0, spread: 1'b1, dual: 1'b1};
      STRAP_SECONDARY: c = '{secondary: 1'b1, spread: 1'b0, dual: 1'b1};
      default: c.spread = 1'b0;
    endcase
    return c;
  endfunction
endpackage

// ---- hw/dead_time_interlock.sv ----
// adaptive dead-time interlock for the two gate drives
`timescale 1ns/1ps
module dead_time_interlock (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hs_req,
  input wire logic i_ls_req,
  input wire logic i_hs_gate_low,
  input wire logic i_ls_gate_low,
  output logic o_hs,
  output logic o_ls
);
  typedef struct packed {
    logic hs;
    logic ls;
    logic [3:0] dly;
  } dt_state_t;
  dt_state_t s;
  dt_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.hs = i_hs_req && !s.ls && i_ls_gate_low; // RL7
    if (!i_ls_req || i_hs_req) begin
      next_s.ls = 1'b0;
      next_s.dly = '0;
    end else if (!s.hs && i_hs_gate_low) begin
      // ls only after the high gate is seen low plus a short delay
      if (s.dly >= 4'(buck_seq_pkg::DT_DELAY_CYC - 1)) begin
        next_s.ls = 1'b1; // RL6
      end else begin
        next_s.dly = s.dly + 4'h1;
      end
    end else begin
      next_s.dly = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_hs = s.hs;
  assign o_ls = s.ls;
endmodule // dead_time_interlock

// ---- hw/hiccup_counter.sv ----
// overload cycle counter for hiccup protection
`timescale 1ns/1ps
module hiccup_counter (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_armed,
  input wire logic i_cur_limit,
  output logic o_expired,
  output logic [9:0] o_count
);
  typedef struct packed {
    logic cl_seen;
    logic active;
    logic [9:0] over_cnt;
    logic [2:0] clean_cnt;
  } hic_state_t;
  hic_state_t s;
  hic_state_t next_s;
  logic limited;

  always_comb begin
    next_s = s;
    limited = s.cl_seen | i_cur_limit;
    next_s.cl_seen = limited;
    if (!i_armed) begin
      next_s = '0;
    end else if (i_tick) begin
      next_s.cl_seen = 1'b0;
      if (limited) begin
        next_s.active = 1'b1;
        next_s.clean_cnt = '0;
      end else if (s.active) begin
        next_s.clean_cnt = s.clean_cnt + 3'h1;
      end
      if ((s.active || limited) && s.over_cnt != 10'(buck_seq_pkg::OVERLOAD_CYCLES)) begin
        next_s.over_cnt = s.over_cnt + 10'h001; // RL1
      end
      if (!limited && s.active && s.clean_cnt == 3'(buck_seq_pkg::CLEAN_CYCLES - 1)) begin
        next_s = '0; // RL2
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0; // RL24
    end else begin
      s <= next_s;
    end
  end

  assign o_expired = (s.over_cnt == 10'(buck_seq_pkg::OVERLOAD_CYCLES));
  assign o_count = s.over_cnt;
endmodule // hiccup_counter
